/* File: rtl/accel_sample_fifo_pkg.sv */
// constants and types shared by the acceleration frame buffer
// assumes one 100 MHz clock domain; no bus beyond the register access port
package accel_sample_fifo_pkg;

    // register offsets on the serial register access port
    localparam logic [7:0] ADDR_MODE_CFG = 8'h3E;
    localparam logic [7:0] ADDR_READOUT  = 8'h3F;

    // reset value, config write mask and idle read values
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [7:0] CFG_WR_MASK   = 8'hC3;
    localparam logic [7:0] EMPTY_READ    = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // field positions inside the buffer mode configuration register
    localparam int MODE_LSB = 6;
    localparam int SEL_LSB  = 0;

    // buffer geometry
    localparam int FRAME_DEPTH = 32;
    localparam int AXIS_BITS   = 16;
    localparam int FRAME_BITS  = 3 * AXIS_BITS;
    localparam logic [2:0] BYTES_ALL = 3'h6;
    localparam logic [2:0] BYTES_ONE = 3'h2;

    typedef enum logic [1:0] {
        MODE_BYPASS    = 2'h0,
        MODE_COLLECT   = 2'h1,
        MODE_OVERWRITE = 2'h2,
        MODE_RESERVED  = 2'h3
    } mode_t;

    typedef enum logic [1:0] {
        AXES_ALL = 2'h0,
        AXIS_X   = 2'h1,
        AXIS_Y   = 2'h2,
        AXIS_Z   = 2'h3
    } axis_sel_t;

endpackage : accel_sample_fifo_pkg

/* File: rtl/frame_store.sv */
// circular frame storage in flip-flops with clear, push, pop and drop-oldest
// assumes the caller never asks for dropOld together with pop
module frame_store #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32,
    localparam int AW   = $clog2(DEPTH)
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    // control
    input  wire logic             clear,
    input  wire logic             push,
    input  wire logic             dropOld,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] pushData,
    // state
    output logic      [WIDTH-1:0] headData,
    output logic      [AW:0]      count,
    output logic                  full,
    output logic                  empty
);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_check
        $error("frame_store: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic             popEff;
    logic             pushEff;
    logic [AW:0]      next_count;

    assign full     = (count == (AW + 1)'(DEPTH));
    assign empty    = (count == '0);
    assign popEff   = !empty && (pop || (push && dropOld));
    assign pushEff  = push && (!full || popEff);
    assign headData = mem[rdPtr];
    assign next_count = count + (AW + 1)'(pushEff) - (AW + 1)'(popEff);

    for (genvar gi = 0; gi < DEPTH; gi++) begin : g_entry
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                mem[gi] <= '0;
            end else if (pushEff && !clear && wrPtr == AW'(gi)) begin
                mem[gi] <= pushData;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else if (clear) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= pushEff ? wrPtr + AW'(1) : wrPtr;
            rdPtr <= popEff ? rdPtr + AW'(1) : rdPtr;
            count <= next_count;
        end
    end

endmodule : frame_store

/* File: rtl/accel_sample_fifo.sv */
// acceleration frame buffer with bypass, collect and overwrite modes
// assumes the serial interface decodes frames into start, byte and end strobes
// Behaviour
// - config write empties buffer, clears full flag
// - mode 00b keeps only newest frame
// - mode 01b stops taking samples at 32
// - mode 10b overwrites oldest frame when full
// - axis select picks stored frame content
// - readout bytes keep acceleration format, flag intact
// - burst from readout port keeps same address
// - partly read frame is discarded whole
// - all axes: X lo/hi, Y lo/hi, Z lo/hi
// - single axis: lo then hi, frames back-to-back
// - readout port is read-only, byte wide, reset to 00h
module accel_sample_fifo #(
    parameter int DEPTH = accel_sample_fifo_pkg::FRAME_DEPTH,
    localparam int CW   = $clog2(DEPTH) + 1
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // acceleration samples
    input  wire logic        sampleValid,
    input  wire logic [15:0] sampleX,
    input  wire logic [15:0] sampleY,
    input  wire logic [15:0] sampleZ,
    // register access strobes from the serial interface
    input  wire logic        accStart,
    input  wire logic [7:0]  accAddr,
    input  wire logic        accWrite,
    input  wire logic [7:0]  accWdata,
    input  wire logic        accRead,
    input  wire logic        accEnd,
    output logic      [7:0]  rdData,
    // buffer status
    output logic             fullFlag,
    output logic      [CW-1:0] frameCount
);

    if (DEPTH < 2) begin : g_check
        $error("accel_sample_fifo: DEPTH must be at least 2");
    end

    localparam int FB = accel_sample_fifo_pkg::FRAME_BITS;
    localparam int AB = accel_sample_fifo_pkg::AXIS_BITS;

    logic [7:0]    cfg;
    logic [7:0]    curAddr;
    logic          addrLock;
    logic [2:0]    byteIdx;
    logic [FB-1:0] heldFrame;

    accel_sample_fifo_pkg::mode_t     mode;
    accel_sample_fifo_pkg::axis_sel_t sel;

    logic          cfgWr;
    logic          portRead;
    logic          cfgRead;
    logic          startFrame;
    logic          midFrame;
    logic          popNow;
    logic [2:0]    bytesPerFrame;
    logic          lastByte;
    logic          pushReq;
    logic          canTake;
    logic          doPush;
    logic          dropOld;
    logic [AB-1:0] selAxis;
    logic [FB-1:0] pushData;
    logic [FB-1:0] headData;
    logic [CW-1:0] storeCount;
    logic          storeFull;
    logic          storeEmpty;
    logic [7:0]    heldByte;
    logic [7:0]    portByte;
    logic [7:0]    next_rdData;
    logic [2:0]    next_byteIdx;
    logic [7:0]    next_curAddr;

    // configuration fields
    assign mode = accel_sample_fifo_pkg::mode_t'(cfg[accel_sample_fifo_pkg::MODE_LSB +: 2]);
    assign sel  = accel_sample_fifo_pkg::axis_sel_t'(cfg[accel_sample_fifo_pkg::SEL_LSB +: 2]);

    // address decode
    assign cfgWr    = accWrite && (curAddr == accel_sample_fifo_pkg::ADDR_MODE_CFG);
    assign cfgRead  = accRead && (curAddr == accel_sample_fifo_pkg::ADDR_MODE_CFG);
    assign portRead = accRead && (curAddr == accel_sample_fifo_pkg::ADDR_READOUT);

    // readout sequencing
    assign bytesPerFrame = (sel == accel_sample_fifo_pkg::AXES_ALL)
                         ? accel_sample_fifo_pkg::BYTES_ALL
                         : accel_sample_fifo_pkg::BYTES_ONE;
    assign lastByte   = (byteIdx == bytesPerFrame - 3'h1);
    assign startFrame = portRead && (byteIdx == 3'h0) && !storeEmpty;
    assign midFrame   = portRead && (byteIdx != 3'h0);
    // the frame leaves storage on its first byte so a partial read loses it
    assign popNow     = startFrame;

    // sample intake per mode; reserved mode takes nothing
    assign pushReq = sampleValid && !cfgWr
                  && (mode != accel_sample_fifo_pkg::MODE_RESERVED);
    assign canTake = (mode != accel_sample_fifo_pkg::MODE_COLLECT)
                  || !storeFull || popNow;
    assign doPush  = pushReq && canTake;
    assign dropOld = doPush && !popNow
                  && (((mode == accel_sample_fifo_pkg::MODE_BYPASS) && !storeEmpty)
                   || ((mode == accel_sample_fifo_pkg::MODE_OVERWRITE) && storeFull));

    // single-axis frames sit in the low word so the byte walk is uniform
    assign selAxis  = (sel == accel_sample_fifo_pkg::AXIS_X) ? sampleX
                    : (sel == accel_sample_fifo_pkg::AXIS_Y) ? sampleY
                    : sampleZ;
    assign pushData = (sel == accel_sample_fifo_pkg::AXES_ALL)
                    ? {sampleZ, sampleY, sampleX}
                    : {{(FB - AB){1'b0}}, selAxis};

    frame_store #(
        .WIDTH (FB),
        .DEPTH (DEPTH)
    ) u_store (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .clear    (cfgWr),
        .push     (doPush),
        .dropOld  (dropOld),
        .pop      (popNow),
        .pushData (pushData),
        .headData (headData),
        .count    (storeCount),
        .full     (storeFull),
        .empty    (storeEmpty)
    );

    // byte selection: raw bits of the stored words, new-data flag untouched
    assign heldByte = heldFrame[{byteIdx, 3'b000} +: 8];
    assign portByte = startFrame ? headData[7:0]
                    : midFrame   ? heldByte
                    : accel_sample_fifo_pkg::EMPTY_READ;
    assign next_rdData = portRead ? portByte
                       : cfgRead  ? (cfg & accel_sample_fifo_pkg::CFG_WR_MASK)
                       : accel_sample_fifo_pkg::UNMAPPED_READ;

    assign next_byteIdx = (accEnd || cfgWr)           ? 3'h0
                        : (startFrame || midFrame)    ? (lastByte ? 3'h0 : byteIdx + 3'h1)
                        : byteIdx;

    // address counter holds when a burst starts at the readout port
    assign next_curAddr = accStart ? accAddr
                        : ((accRead || accWrite) && !addrLock) ? curAddr + 8'h01
                        : curAddr;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= accel_sample_fifo_pkg::CFG_RESET;
        end else if (cfgWr) begin
            cfg <= accWdata & accel_sample_fifo_pkg::CFG_WR_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            curAddr  <= 8'h00;
            addrLock <= 1'b0;
        end else begin
            curAddr  <= next_curAddr;
            addrLock <= accStart ? (accAddr == accel_sample_fifo_pkg::ADDR_READOUT)
                                 : addrLock;
        end
    end

    // readout port is byte wide and never written
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdData    <= 8'h00;
            byteIdx   <= 3'h0;
            heldFrame <= '0;
        end else begin
            rdData    <= (accRead) ? next_rdData : rdData;
            byteIdx   <= next_byteIdx;
            heldFrame <= startFrame ? headData : heldFrame;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fullFlag   <= 1'b0;
            frameCount <= '0;
        end else begin
            fullFlag   <= storeFull && !cfgWr;
            frameCount <= cfgWr ? '0 : storeCount;
        end
    end

    // checks
    AST_CFG_CLEAR: assert property (@(posedge clk_sys) disable iff (!arst_n)
        cfgWr |=> (storeCount == '0) && !fullFlag)
        else $error("config write did not empty buffer");

    AST_BYPASS_ONE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (mode == accel_sample_fifo_pkg::MODE_BYPASS) && sampleValid && !cfgWr
        |=> (storeCount == CW'(1)) && (u_store.headData == $past(pushData)))
        else $error("bypass mode did not keep newest frame only");

    AST_COLLECT_STOP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (mode == accel_sample_fifo_pkg::MODE_COLLECT) && storeFull && !popNow && !cfgWr
        |=> storeFull && $stable(u_store.headData))
        else $error("collect mode accepted a sample while full");

    AST_OVERWRITE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (mode == accel_sample_fifo_pkg::MODE_OVERWRITE) && storeFull && sampleValid
        && !popNow && !cfgWr |-> dropOld ##1 storeFull)
        else $error("overwrite mode did not replace oldest frame");

    AST_AXIS_SEL: assert property (@(posedge clk_sys) disable iff (!arst_n)
        doPush && (sel == accel_sample_fifo_pkg::AXIS_Y)
        |-> pushData == {{(FB - AB){1'b0}}, sampleY})
        else $error("axis selection stored wrong data");

    AST_FIRST_BYTE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        startFrame |=> (rdData == $past(headData[7:0])) && (byteIdx == 3'h1))
        else $error("frame readout did not start with low byte");

    AST_BURST_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
        accRead && addrLock && !accStart |=> $stable(curAddr))
        else $error("address advanced in readout burst");

    AST_PARTIAL: assert property (@(posedge clk_sys) disable iff (!arst_n)
        accEnd && (byteIdx != 3'h0) |=> (byteIdx == 3'h0))
        else $error("partial frame was not discarded");

    AST_ONE_AXIS_WRAP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        midFrame && (sel != accel_sample_fifo_pkg::AXES_ALL) && !accEnd
        |=> (byteIdx == 3'h0) && (rdData == $past(heldFrame[15:8])))
        else $error("single axis frame is not two bytes");

    AST_FULL_FLAG: assert property (@(posedge clk_sys) disable iff (!arst_n)
        storeFull && !cfgWr |=> fullFlag)
        else $error("full flag missing at full buffer");

    AST_CLEAR_INDEX: assert property (@(posedge clk_sys) disable iff (!arst_n)
        cfgWr |=> (byteIdx == 3'h0) && (frameCount == '0))
        else $error("config write left a partial frame");

    AST_BYPASS_DEPTH: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (mode == accel_sample_fifo_pkg::MODE_BYPASS) |-> (storeCount <= CW'(1)))
        else $error("bypass mode held more than one frame");

    AST_COLLECT_FILL: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (mode == accel_sample_fifo_pkg::MODE_COLLECT) && doPush && !popNow && !cfgWr
        |=> (storeCount == $past(storeCount) + CW'(1)))
        else $error("collect mode lost a sample below full");

    AST_OVERWRITE_GROW: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (mode == accel_sample_fifo_pkg::MODE_OVERWRITE) && doPush && !storeFull
        && !popNow && !cfgWr |=> (storeCount == $past(storeCount) + CW'(1)))
        else $error("overwrite mode lost a sample below full");

    AST_CAPACITY: assert property (@(posedge clk_sys) disable iff (!arst_n)
        storeCount <= CW'(DEPTH))
        else $error("buffer holds more frames than its depth");

    AST_COUNT_TRACK: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !cfgWr |=> (frameCount == $past(storeCount)))
        else $error("frame count does not follow storage");

    AST_FULL_DROP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !storeFull |=> !fullFlag)
        else $error("full flag set below full buffer");

    AST_ADDR_STEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (accRead || accWrite) && !addrLock && !accStart
        |=> (curAddr == $past(curAddr) + 8'h01))
        else $error("address did not advance outside readout burst");

    AST_ADDR_LOAD: assert property (@(posedge clk_sys) disable iff (!arst_n)
        accStart |=> (curAddr == $past(accAddr))
        && (addrLock == ($past(accAddr) == accel_sample_fifo_pkg::ADDR_READOUT)))
        else $error("start address not loaded");

    AST_LAST_Z: assert property (@(posedge clk_sys) disable iff (!arst_n)
        midFrame && (sel == accel_sample_fifo_pkg::AXES_ALL) && (byteIdx == 3'h5)
        |=> (byteIdx == 3'h0) && (rdData == $past(heldFrame[FB-1:FB-8])))
        else $error("all axis frame did not end with Z high byte");

    AST_SINGLE_LOW: assert property (@(posedge clk_sys) disable iff (!arst_n)
        doPush && (sel != accel_sample_fifo_pkg::AXES_ALL) |-> (pushData[FB-1:AB] == '0))
        else $error("single axis frame has data above its low word");

    AST_MID_KEEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        midFrame && !doPush && !cfgWr |=> (storeCount == $past(storeCount)))
        else $error("mid frame read removed another frame");

    AST_PORT_RO: assert property (@(posedge clk_sys) disable iff (!arst_n)
        accWrite && (curAddr == accel_sample_fifo_pkg::ADDR_READOUT)
        |=> $stable(cfg) && $stable(rdData) && $stable(byteIdx))
        else $error("write to readout port changed state");

    AST_RD_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !accRead |=> $stable(rdData))
        else $error("read data changed without a read");

    COV_OVERWRITE: cover property (@(posedge clk_sys) disable iff (!arst_n)
        (mode == accel_sample_fifo_pkg::MODE_OVERWRITE) && dropOld);
    COV_COLLECT_FULL: cover property (@(posedge clk_sys) disable iff (!arst_n)
        (mode == accel_sample_fifo_pkg::MODE_COLLECT) && storeFull && sampleValid);
    COV_FULL_FRAME: cover property (@(posedge clk_sys) disable iff (!arst_n)
        midFrame && lastByte && (sel == accel_sample_fifo_pkg::AXES_ALL));
    COV_PARTIAL_END: cover property (@(posedge clk_sys) disable iff (!arst_n)
        accEnd && (byteIdx != 3'h0));
    COV_ONE_AXIS: cover property (@(posedge clk_sys) disable iff (!arst_n)
        startFrame && (sel != accel_sample_fifo_pkg::AXES_ALL));

endmodule : accel_sample_fifo

/* File: test/host_model.sv */
// host side model issuing register access strobes to the frame buffer
// assumes strobes change at the falling edge of clk_sys, one strobe per cycle
module host_model (
    // clock
    input  wire logic       clk_sys,
    // register access strobes
    output logic            accStart,
    output logic [7:0]      accAddr,
    output logic            accWrite,
    output logic [7:0]      accWdata,
    output logic            accRead,
    output logic            accEnd,
    // read return
    input  wire logic [7:0] rdData
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        accStart = 1'b0;
        accAddr  = 8'h00;
        accWrite = 1'b0;
        accWdata = 8'h00;
        accRead  = 1'b0;
        accEnd   = 1'b0;
    end

    task automatic start(input logic [7:0] a);
        @(negedge clk_sys);
        accStart = 1'b1;
        accAddr  = a;
        @(negedge clk_sys);
        accStart = 1'b0;
        accAddr  = ~a;
    endtask : start

    task automatic wr(input logic [7:0] d);
        @(negedge clk_sys);
        accWrite = 1'b1;
        // reserved mode encoding is never sent
        accWdata = (d[7:6] == 2'h3) ? {2'h2, d[5:0]} : d;
        @(negedge clk_sys);
        accWrite = 1'b0;
        accWdata = ~accWdata;
    endtask : wr

    task automatic rd(output logic [7:0] d);
        @(negedge clk_sys);
        accRead = 1'b1;
        @(negedge clk_sys);
        accRead = 1'b0;
        d       = rdData;
    endtask : rd

    task automatic stop();
        @(negedge clk_sys);
        accEnd = 1'b1;
        @(negedge clk_sys);
        accEnd = 1'b0;
    endtask : stop
endmodule : host_model

/* File: test/tb_top.sv */
// self-checking bench for the acceleration frame buffer, depth shortened to 4
// assumes host_model drives the register strobes; samples driven here
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D = 4;
    logic clk_sys, arst_n, sampleValid, accStart, accWrite, accRead, accEnd, fullFlag;
    logic [15:0] sampleX, sampleY, sampleZ;
    logic [7:0]  accAddr, accWdata, rdData;
    logic [2:0]  frameCount;
    logic [7:0]  got [0:31];
    int          fails, n_compared;

    accel_sample_fifo #(.DEPTH(D)) i_accel_sample_fifo (.clk_sys(clk_sys), .arst_n(arst_n),
        .sampleValid(sampleValid), .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ),
        .accStart(accStart), .accAddr(accAddr), .accWrite(accWrite), .accWdata(accWdata),
        .accRead(accRead), .accEnd(accEnd), .rdData(rdData), .fullFlag(fullFlag),
        .frameCount(frameCount));
    host_model i_host_model (.clk_sys(clk_sys), .accStart(accStart), .accAddr(accAddr),
        .accWrite(accWrite), .accWdata(accWdata), .accRead(accRead), .accEnd(accEnd),
        .rdData(rdData));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] eb(int k, int ax, bit hi);
        logic [15:0] w;
        w = {8'(8'h10 + 8'h20 * ax + k), 8'(8'h20 + 8'h20 * ax + k)};
        return hi ? w[15:8] : w[7:0];
    endfunction : eb

    task automatic chk(string name, logic [7:0] exp, logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic push(int k);
        @(negedge clk_sys);
        sampleValid = 1'b1;
        sampleX = {eb(k, 0, 1), eb(k, 0, 0)};
        sampleY = {eb(k, 1, 1), eb(k, 1, 0)};
        sampleZ = {eb(k, 2, 1), eb(k, 2, 0)};
        @(negedge clk_sys);
        sampleValid = 1'b0;
        sampleX = ~sampleX;
    endtask : push

    task automatic pushN(int k0, int n);
        for (int k = k0; k < k0 + n; k++) push(k);
    endtask : pushN

    task automatic cfg(logic [7:0] d);
        i_host_model.start(8'h3E);
        i_host_model.wr(d);
        i_host_model.stop();
    endtask : cfg

    task automatic burst(logic [7:0] a, int n);
        i_host_model.start(a);
        for (int i = 0; i < n; i++) i_host_model.rd(got[i]);
        i_host_model.stop();
    endtask : burst

    task automatic status(int c, int f);
        repeat (2) @(negedge clk_sys);
        chk("frameCount", 8'(c), 8'(frameCount));
        if (f >= 0) chk("fullFlag", 8'(f), 8'(fullFlag));
    endtask : status

    task automatic t_reset();
        status(0, 0);
        chk("rdData", 8'h00, rdData);
        burst(8'h3E, 1);
        chk("cfg reset", 8'h00, got[0]);
        burst(8'h3F, 1);
        chk("empty read", 8'h00, got[0]);
    endtask : t_reset

    task automatic t_collect();
        cfg(8'h40);
        pushN(0, D + 1);
        status(D, 1);
        burst(8'h3F, D * 6 + 1);
        for (int i = 0; i < D * 6; i++) chk("frame byte", eb(i / 6, (i % 6) / 2, i[0]), got[i]);
        chk("empty read", 8'h00, got[D * 6]);
        status(0, 0);
    endtask : t_collect

    task automatic t_overwrite();
        cfg(8'h80);
        pushN(0, D + 2);
        status(D, 1);
        burst(8'h3F, 6);
        for (int i = 0; i < 6; i++) chk("oldest kept", eb(2, i / 2, i[0]), got[i]);
        push(9);
        status(D, 1);
        cfg(8'h80);
        status(0, 0);
    endtask : t_overwrite

    task automatic t_bypass();
        cfg(8'h00);
        pushN(0, 3);
        status(1, -1);
        burst(8'h3F, 6);
        for (int i = 0; i < 6; i++) chk("newest frame", eb(2, i / 2, i[0]), got[i]);
    endtask : t_bypass

    task automatic t_axis();
        for (int s = 1; s < 4; s++) begin
            cfg(8'h40 | 8'(s));
            pushN(0, 2);
            burst(8'h3F, 4);
            for (int i = 0; i < 4; i++) chk("axis byte", eb(i / 2, s - 1, i[0]), got[i]);
        end
    endtask : t_axis

    task automatic t_partial();
        cfg(8'h40);
        pushN(0, 2);
        burst(8'h3F, 2);
        status(1, 0);
        burst(8'h3F, 2);
        chk("next frame lo", eb(1, 0, 0), got[0]);
        chk("next frame hi", eb(1, 0, 1), got[1]);
    endtask : t_partial

    task automatic t_regs();
        cfg(8'h7D);
        burst(8'h3E, 1);
        chk("cfg mask", 8'h41, got[0]);
        i_host_model.start(8'h3F);
        i_host_model.wr(8'hAA);
        i_host_model.stop();
        push(5);
        burst(8'h3F, 1);
        chk("read only port", eb(5, 0, 0), got[0]);
        burst(8'h3D, 1);
        chk("unmapped", 8'h00, got[0]);
    endtask : t_regs

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #100000;
        fails++;
        end_of_test();
    end

    initial begin
        arst_n = 1'b0;
        sampleValid = 1'b0;
        sampleX = 16'h0000;
        sampleY = 16'h0000;
        sampleZ = 16'h0000;
        fails = 0;
        n_compared = 0;
        repeat (6) @(negedge clk_sys);
        arst_n = 1'b1;
        t_reset();
        t_collect();
        t_overwrite();
        t_bypass();
        t_axis();
        t_partial();
        t_regs();
        end_of_test();
    end
endmodule : tb_top
